/* File: common/vvm_pkg.sv */
/*
   Constants for the variable vector interrupt map: register byte offsets,
   field positions, reset values and the slot numbering of the vector table.
   Assumes a 32-bit APB register bus and a 20-bit processor address space.
*/
//
// Contract
// - Vector table is a 256-byte area starting at the software-written base pointer.
// - Each slot holds a four-byte handler address; the block fetches it on acceptance.
// - Slot n lies at base plus 4n through base plus 4n+3.
// - Break uses number 0; software numbers 32-63 use the table; never gated.
// - External irq 3, input timers 5/4/3, output timers 7/6 map to numbers 4-9.
// - Number 10 is output timer 5 or bus collision, chosen by bit 4 at 035E.
// - DMA channels 0/1, key input, conversion done map to numbers 11-14.
// - Numbers 15/16 are serial 2 transmit/receive, or NACK/ACK in two-wire mode.
// - Serial channel 0 and 1 transmit/receive map to numbers 17-20.
// - Output timers 0-2 map to numbers 21-23, input timers 0-2 to 26-28.
// - Numbers 24/25 choose timer 3/4 or external irq 4/5 by bits 6/7 at 035F.
// - External irqs 0, 1, 2 map to numbers 29, 30, 31.
// - Software numbers 32-63 occupy offsets 128 through 255.
// - Maskable requests gated by global enable, source level and cpu threshold.
// - Each source has a software-readable pending request bit.
// - Request bit and level field share one control register per source.
// - Global enable and threshold live in the processor flag word.
// - Non-maskable and software vectors bypass the enable and priority gating.
// - Accept only when enable is 1, request is 1 and level exceeds threshold.
// - Level is 3 bits; 0 disables, 1 lowest through 7 highest.
// - Hardware sets request, clears on acceptance; software may only clear it.
// - Global enable resets to 0.

package vvm_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int          ADDR_W      = 20;
   localparam int          PADDR_W     = 12;
   localparam int          NUM_SLOTS   = 32;
   localparam int          NUM_W       = 6;
   localparam int          LVL_W       = 3;
   localparam int          TABLE_BYTES = 256;
   localparam int          SLOT_BYTES  = 4;
   localparam int          FIRST_SLOT  = 4;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_VECTOR_BASE = 12'h000;
   localparam logic [11:0] OFS_FLAG_WORD   = 12'h004;
   localparam logic [11:0] OFS_STATUS      = 12'h008;
   localparam logic [11:0] OFS_HANDLER     = 12'h00C;
   localparam logic [11:0] OFS_MODE        = 12'h010;
   localparam logic [11:0] OFS_SLOT_BASE   = 12'h100;
   localparam logic [11:0] IDX_CAUSE_SEL_A = 12'h35E;
   localparam logic [11:0] IDX_CAUSE_SEL_B = 12'h35F;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int          FLAG_GIE_BIT   = 6;
   localparam int          FLAG_THR_LSB   = 12;
   localparam int          SLOT_REQ_BIT   = 3;
   localparam int          SEL_COLL_BIT   = 4;
   localparam int          SEL_EXT4_BIT   = 6;
   localparam int          SEL_EXT5_BIT   = 7;
   localparam int          MODE_2WIRE_BIT = 0;
   localparam int          STAT_PEND_BIT  = 31;
   localparam int          STAT_LVL_LSB   = 8;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] RST_VECTOR_BASE = 20'h00000;
   localparam logic              RST_GIE         = 1'b0;
   localparam logic [LVL_W-1:0]  RST_THRESHOLD   = 3'h0;
   localparam logic [LVL_W-1:0]  RST_LEVEL       = 3'h0;

endpackage : vvm_pkg

/* File: logic/vvm_top.sv */
/*
   Variable vector interrupt map: per-source control registers, priority
   gating and arbitration, and vector fetch from the relocatable table.
   Assumes peripheral requests arrive as one-cycle synchronous pulses, and a
   single-word memory read port that answers with mem_rvalid some cycles later.
*/
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns

module vvm_top
   import vvm_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [PADDR_W-1:0]   paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Peripheral request pulses
   input  wire logic [5:0]           external_irq,
   input  wire logic [7:0]           output_timer_irq,
   input  wire logic [5:0]           input_timer_irq,
   input  wire logic [1:0]           dma_channel_irq,
   input  wire logic                 key_input_irq,
   input  wire logic                 conversion_done_irq,
   input  wire logic [2:0]           serial_tx_irq,
   input  wire logic [2:0]           serial_rx_irq,
   input  wire logic                 bus_collision_irq,
   input  wire logic                 serial_2_nack_irq,
   input  wire logic                 serial_2_ack_irq,
   // Core interrupt sequencer
   output logic                      irq_request,
   output logic      [NUM_W-1:0]     irq_number,
   output logic      [LVL_W-1:0]     irq_level,
   input  wire logic                 irq_accept,
   input  wire logic                 sw_int_strobe,
   input  wire logic [NUM_W-1:0]     sw_int_number,
   output logic                      handler_valid,
   output logic      [ADDR_W-1:0]    handler_address,
   output logic      [NUM_W-1:0]     handler_number,
   // Vector table read port
   output logic                      mem_rd,
   output logic      [ADDR_W-1:0]    mem_addr,
   input  wire logic                 mem_rvalid,
   input  wire logic [31:0]          mem_rdata
);

   typedef enum logic [0:0] {
      VV_IDLE,
      VV_WAIT
   } vvm_state_e;

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [ADDR_W-1:0]    vector_base_pointer;
   logic                 global_enable;
   logic [LVL_W-1:0]     cpu_priority_threshold;
   logic                 sel_collision;
   logic                 sel_ext4;
   logic                 sel_ext5;
   logic                 two_wire_mode;
   // Nets: every slot drives only its own element
   wire logic [NUM_SLOTS-1:0] req_bit;
   wire logic [LVL_W-1:0]     level [0:NUM_SLOTS-1];
   vvm_state_e           state;
   logic [NUM_W-1:0]     fetch_number;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   wire logic             setup_rd  = psel & ~penable & ~pwrite;
   wire logic             setup_ph  = psel & ~penable;
   wire logic             apb_wr    = psel & penable & pwrite & pready;
   wire logic             hit_base  = paddr == OFS_VECTOR_BASE;
   wire logic             hit_flag  = paddr == OFS_FLAG_WORD;
   wire logic             hit_stat  = paddr == OFS_STATUS;
   wire logic             hit_hand  = paddr == OFS_HANDLER;
   wire logic             hit_mode  = paddr == OFS_MODE;
   wire logic             hit_sel_a = paddr == {IDX_CAUSE_SEL_A[9:0], 2'b00};
   wire logic             hit_sel_b = paddr == {IDX_CAUSE_SEL_B[9:0], 2'b00};
   wire logic             hit_slot  = (paddr[11:7] == OFS_SLOT_BASE[11:7]) &
                                      (paddr[1:0] == 2'b00);
   wire logic [4:0]       slot_idx  = paddr[6:2];
   wire logic             mapped    = hit_base | hit_flag | hit_stat | hit_hand |
                                      hit_mode | hit_sel_a | hit_sel_b | hit_slot;

   // ---------------------------------------------------------------
   // Source to slot mapping
   // ---------------------------------------------------------------
   logic [NUM_SLOTS-1:0] slot_event;

   assign slot_event[0]  = 1'b0;
   assign slot_event[3:1] = 3'b000;
   assign slot_event[4]  = external_irq[3];
   assign slot_event[5]  = input_timer_irq[5];
   assign slot_event[6]  = input_timer_irq[4];
   assign slot_event[7]  = input_timer_irq[3];
   assign slot_event[8]  = output_timer_irq[7];
   assign slot_event[9]  = output_timer_irq[6];
   assign slot_event[10] = sel_collision ? bus_collision_irq
                                         : output_timer_irq[5];
   assign slot_event[11] = dma_channel_irq[0];
   assign slot_event[12] = dma_channel_irq[1];
   assign slot_event[13] = key_input_irq;
   assign slot_event[14] = conversion_done_irq;
   assign slot_event[15] = two_wire_mode ? serial_2_nack_irq
                                         : serial_tx_irq[2];
   assign slot_event[16] = two_wire_mode ? serial_2_ack_irq
                                         : serial_rx_irq[2];
   assign slot_event[17] = serial_tx_irq[0];
   assign slot_event[18] = serial_rx_irq[0];
   assign slot_event[19] = serial_tx_irq[1];
   assign slot_event[20] = serial_rx_irq[1];
   assign slot_event[21] = output_timer_irq[0];
   assign slot_event[22] = output_timer_irq[1];
   assign slot_event[23] = output_timer_irq[2];
   assign slot_event[24] = sel_ext4 ? external_irq[4]
                                    : output_timer_irq[3];
   assign slot_event[25] = sel_ext5 ? external_irq[5]
                                    : output_timer_irq[4];
   assign slot_event[26] = input_timer_irq[0];
   assign slot_event[27] = input_timer_irq[1];
   assign slot_event[28] = input_timer_irq[2];
   assign slot_event[29] = external_irq[0];
   assign slot_event[30] = external_irq[1];
   assign slot_event[31] = external_irq[2];

   // ---------------------------------------------------------------
   // Acceptance and vector selection
   // ---------------------------------------------------------------
   // Software vectors win over a same-cycle hardware accept; the core issues one at a time.
   wire logic             idle      = state == VV_IDLE;
   wire logic             take_sw   = idle & sw_int_strobe;
   wire logic             take_hw   = idle & ~sw_int_strobe & irq_accept &
                                      irq_request & req_bit[irq_number[4:0]];
   wire logic [NUM_W-1:0] take_num  = take_sw ? sw_int_number : irq_number;
   wire logic [ADDR_W-1:0] slot_ofs = {{(ADDR_W-NUM_W-2){1'b0}}, take_num, 2'b00};
   wire logic [ADDR_W-1:0] slot_adr = vector_base_pointer + slot_ofs;

   // ---------------------------------------------------------------
   // Per-slot control registers
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g = g + 1) begin : g_slot
         if (g >= FIRST_SLOT) begin : g_live
            wire logic wr_this  = apb_wr & hit_slot & (slot_idx == g);
            wire logic sw_clr   = wr_this & ~pwdata[SLOT_REQ_BIT];
            wire logic hw_clr   = take_hw & (irq_number == g);
            logic             req_q;
            logic [LVL_W-1:0] lvl_q;
            always_ff @(posedge clk or negedge resetn) begin
               if (!resetn) begin
                  req_q <= 1'b0;
                  lvl_q <= RST_LEVEL;
               end else begin
                  // A new event in the clearing cycle is kept
                  req_q <= (req_q & ~sw_clr & ~hw_clr) | slot_event[g];
                  if (wr_this) begin
                     lvl_q <= pwdata[LVL_W-1:0];
                  end
               end
            end
            assign req_bit[g] = req_q;
            assign level[g]   = lvl_q;
         end else begin : g_rsvd
            assign req_bit[g] = 1'b0;
            assign level[g]   = RST_LEVEL;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   // Highest level wins; on a tie the lower number wins.
   logic [LVL_W-1:0] best_lvl;
   logic [NUM_W-1:0] best_num;

   always_comb begin
      best_lvl = RST_LEVEL;
      best_num = '0;
      for (int i = FIRST_SLOT; i < NUM_SLOTS; i++) begin
         if (global_enable && req_bit[i] &&
             (level[i] > cpu_priority_threshold) &&
             (level[i] > best_lvl)) begin
            best_lvl = level[i];
            best_num = NUM_W'(i);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_request <= 1'b0;
         irq_number  <= '0;
         irq_level   <= RST_LEVEL;
      end else begin
         // Drop the request during the clear so the core never sees a stale slot
         irq_request <= (best_lvl != RST_LEVEL) & ~take_hw;
         irq_number  <= best_num;
         irq_level   <= best_lvl;
      end
   end

   // ---------------------------------------------------------------
   // Global registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vector_base_pointer    <= RST_VECTOR_BASE;
         global_enable          <= RST_GIE;
         cpu_priority_threshold <= RST_THRESHOLD;
         sel_collision          <= 1'b0;
         sel_ext4               <= 1'b0;
         sel_ext5               <= 1'b0;
         two_wire_mode          <= 1'b0;
      end else if (apb_wr) begin
         if (hit_base) begin
            vector_base_pointer <= pwdata[ADDR_W-1:0];
         end
         if (hit_flag) begin
            global_enable          <= pwdata[FLAG_GIE_BIT];
            cpu_priority_threshold <= pwdata[FLAG_THR_LSB +: LVL_W];
         end
         if (hit_sel_a) begin
            sel_collision <= pwdata[SEL_COLL_BIT];
         end
         if (hit_sel_b) begin
            sel_ext4 <= pwdata[SEL_EXT4_BIT];
            sel_ext5 <= pwdata[SEL_EXT5_BIT];
         end
         if (hit_mode) begin
            two_wire_mode <= pwdata[MODE_2WIRE_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // Vector fetch
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state           <= VV_IDLE;
         mem_rd          <= 1'b0;
         mem_addr        <= '0;
         fetch_number    <= '0;
         handler_valid   <= 1'b0;
         handler_address <= '0;
         handler_number  <= '0;
      end else begin
         mem_rd        <= 1'b0;
         handler_valid <= 1'b0;
         case (state)
            VV_IDLE: begin
               if (take_sw || take_hw) begin
                  mem_rd       <= 1'b1;
                  mem_addr     <= slot_adr;
                  fetch_number <= take_num;
                  state        <= VV_WAIT;
               end
            end
            VV_WAIT: begin
               if (mem_rvalid) begin
                  handler_valid   <= 1'b1;
                  handler_address <= mem_rdata[ADDR_W-1:0];
                  handler_number  <= fetch_number;
                  state           <= VV_IDLE;
               end
            end
            default: begin
               state <= VV_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   wire logic [31:0] rd_base  = {{(32-ADDR_W){1'b0}}, vector_base_pointer};
   wire logic [31:0] rd_flag  = (32'(global_enable) << FLAG_GIE_BIT) |
                                (32'(cpu_priority_threshold) << FLAG_THR_LSB);
   wire logic [31:0] rd_stat  = (32'(irq_request) << STAT_PEND_BIT) |
                                (32'(irq_level) << STAT_LVL_LSB) |
                                32'(irq_number);
   wire logic [31:0] rd_hand  = {{(32-ADDR_W){1'b0}}, handler_address};
   wire logic [31:0] rd_mode  = 32'(two_wire_mode) << MODE_2WIRE_BIT;
   wire logic [31:0] rd_sel_a = 32'(sel_collision) << SEL_COLL_BIT;
   wire logic [31:0] rd_sel_b = (32'(sel_ext4) << SEL_EXT4_BIT) |
                                (32'(sel_ext5) << SEL_EXT5_BIT);
   wire logic [31:0] rd_slot  = (32'(req_bit[slot_idx]) << SLOT_REQ_BIT) |
                                32'(level[slot_idx]);
   wire logic [31:0] rd_mux   = hit_base  ? rd_base  :
                                hit_flag  ? rd_flag  :
                                hit_stat  ? rd_stat  :
                                hit_hand  ? rd_hand  :
                                hit_mode  ? rd_mode  :
                                hit_sel_a ? rd_sel_a :
                                hit_sel_b ? rd_sel_b :
                                hit_slot  ? rd_slot  : 32'h00000000;

   // No wait state: data is captured in setup so prdata leaves a flip-flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~mapped;
         if (setup_rd) begin
            prdata <= rd_mux;
         end
      end
   end

endmodule // vvm_top

/* File: bench/vvm_mem_model.sv */
/*
   Vector table memory seen by the block's read port.
   Assumes one read in flight; slow selects a longer answer time.
*/
`timescale 1ns/1ns
module vvm_mem_model (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        mem_rd,
   input  wire logic [19:0] mem_addr,
   input  wire logic        slow,
   output logic             mem_rvalid,
   output logic      [31:0] mem_rdata
);
   logic [1:0]  cnt;
   logic [19:0] a_q;
   // Outside the answer cycle the data inverts each cycle so stale values never match
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt        <= 2'h0;
         a_q        <= 20'h00000;
         mem_rvalid <= 1'b0;
         mem_rdata  <= 32'h00000000;
      end else begin
         if (mem_rd) cnt <= slow ? 2'h3 : 2'h1;
         else if (cnt != 2'h0) cnt <= cnt - 2'h1;
         if (mem_rd) a_q <= mem_addr;
         mem_rvalid <= (cnt == 2'h1) && !mem_rd;
         mem_rdata  <= (cnt == 2'h1) ? {12'h000, a_q ^ 20'h5A5A5} : ~mem_rdata;
      end
   end
endmodule // vvm_mem_model

/* File: bench/vvm_props.sv */
/*
   Port-level checks of the vector map block.
   Assumes it is bound to vvm_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module vvm_props
   import vvm_pkg::*;
(
   // Clock, reset and APB
   input wire logic clk, resetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata, mem_rdata,
   // Interrupt path
   input wire logic irq_request, irq_accept, sw_int_strobe, mem_rd, mem_rvalid, handler_valid,
   input wire logic [LVL_W-1:0] irq_level,
   input wire logic [NUM_W-1:0] irq_number, sw_int_number,
   input wire logic [ADDR_W-1:0] mem_addr, handler_address
);
   logic [ADDR_W-1:0] base_q;
   logic [LVL_W-1:0]  thr_q;
   logic              gie_q, busy_q;
   wire               wr = psel && penable && pwrite && pready;
   // Shadow of software state, so gating can be judged from the ports alone
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         base_q <= '0;
         thr_q  <= '0;
         gie_q  <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (wr && paddr == OFS_VECTOR_BASE) base_q <= pwdata[ADDR_W-1:0];
         if (wr && paddr == OFS_FLAG_WORD) gie_q <= pwdata[FLAG_GIE_BIT];
         if (wr && paddr == OFS_FLAG_WORD) thr_q <= pwdata[FLAG_THR_LSB+:LVL_W];
         busy_q <= mem_rd || (busy_q && !mem_rvalid);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_PREADY: assert property (psel && !penable |=> pready && penable)
      else $error("pready missing after setup");
   AST_ERR: assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_GATE: assert property (irq_request |-> $past(gie_q) && irq_level > $past(thr_q))
      else $error("request offered against enable or threshold");
   AST_RSVD: assert property (irq_request |-> irq_number >= 6'h04 && irq_number < 6'h20)
      else $error("reserved or software number offered");
   AST_DROP: assert property (mem_rd && $past(irq_accept && !sw_int_strobe) |-> !irq_request)
      else $error("request still offered after acceptance");
   AST_ADDR: assert property (mem_rd |-> mem_addr[1:0] == 2'h0 && (mem_addr - base_q) < 256)
      else $error("fetch outside the vector table");
   AST_SWFETCH: assert property (sw_int_strobe && !busy_q && !mem_rd |=>
      mem_rd && mem_addr == base_q + {$past(sw_int_number), 2'b00}) else $error("bad sw fetch");
   AST_ORIGIN: assert property (mem_rd |-> $past(irq_accept || sw_int_strobe))
      else $error("fetch without a cause");
   AST_HANDLER: assert property (mem_rvalid && busy_q |=>
      handler_valid && handler_address == $past(mem_rdata[ADDR_W-1:0])) else $error("bad handler");
endmodule // vvm_props

bind vvm_top vvm_props u_props (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
   .mem_rdata(mem_rdata), .irq_request(irq_request), .irq_accept(irq_accept),
   .sw_int_strobe(sw_int_strobe), .mem_rd(mem_rd), .mem_rvalid(mem_rvalid),
   .handler_valid(handler_valid), .irq_level(irq_level), .irq_number(irq_number),
   .sw_int_number(sw_int_number), .mem_addr(mem_addr), .handler_address(handler_address));

/* File: bench/test_variable_vector_interrupt_map.sv */
/*
   Self-checking bench: source-to-number table, gating, priority, software
   clear, software vectors, reserved slots and mid-run reset.
   Assumes vvm_top, the memory model and the bound checker.
*/
`timescale 1ns/1ns
module test_variable_vector_interrupt_map;
   import vvm_pkg::*;
   logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
   logic        irq_accept = 0, sw_int_strobe = 0, pready, pslverr, erv, irq_request;
   logic        handler_valid, mem_rd, mem_rvalid;
   logic [11:0] paddr = '0, sa;
   logic [31:0] pwdata = '0, prdata, rdv, mem_rdata;
   logic [32:0] src = '0;
   logic [5:0]  sw_int_number = '0, irq_number, handler_number;
   logic [2:0]  irq_level;
   logic [19:0] mem_addr, handler_address;
   int          fail_count = 0, check_count = 0, alt, num, bn;
   // Rows: alternate-source flag * 10000 + number * 100 + request input index
   int rows [33] = '{403, 519, 618, 717, 813, 912, 1011, 11030, 1120, 1221, 1322, 1423, 1526,
      1629, 11531, 11632, 1724, 1827, 1925, 2028, 2106, 2207, 2308, 2409, 12404, 2510, 12505,
      2614, 2715, 2816, 2900, 3001, 3102};
   localparam logic [19:0] BASE = 20'h12340;
   initial forever #2 clk = ~clk;
   vvm_top u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_irq(src[5:0]), .output_timer_irq(src[13:6]), .input_timer_irq(src[19:14]),
      .dma_channel_irq(src[21:20]), .key_input_irq(src[22]), .conversion_done_irq(src[23]),
      .serial_tx_irq(src[26:24]), .serial_rx_irq(src[29:27]), .bus_collision_irq(src[30]),
      .serial_2_nack_irq(src[31]), .serial_2_ack_irq(src[32]), .irq_request(irq_request),
      .irq_number(irq_number), .irq_level(irq_level), .irq_accept(irq_accept),
      .sw_int_strobe(sw_int_strobe), .sw_int_number(sw_int_number),
      .handler_valid(handler_valid), .handler_address(handler_address),
      .handler_number(handler_number), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   vvm_mem_model u_mem (.clk(clk), .resetn(resetn), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .slow(slow), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   task print_verdict;
      $display("checks=%0d failures=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Request held until the edge at which pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk); penable <= 1;
      do begin
         @(posedge clk);
         if (++i > 50) begin fail_count++; print_verdict; end
      end while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task wt(input int s);
      int i;
      i = 0;
      @(negedge clk);
      while (((s == 0) ? irq_request : (s == 1) ? mem_rd : handler_valid) !== 1'b1) begin
         if (++i > 60) begin fail_count++; print_verdict; end
         @(negedge clk);
      end
   endtask
   task fetch(input logic [5:0] n, input logic swt);
      logic [19:0] ea;
      ea = BASE + {n, 2'b00};
      @(posedge clk); sw_int_number <= n; sw_int_strobe <= swt; irq_accept <= !swt;
      @(posedge clk); sw_int_strobe <= 0; irq_accept <= 0;
      wt(1); chk(mem_addr, ea);
      wt(2); chk(handler_address, ea ^ 20'h5A5A5);
      chk(handler_number, n);
   endtask
   task pulse(input int b);
      @(posedge clk); src <= 33'h1 << b;
      @(posedge clk); src <= '0;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1;
      apb(0, OFS_FLAG_WORD, 0); chk(rdv, 0);
      apb(1, OFS_VECTOR_BASE, BASE); apb(1, OFS_FLAG_WORD, 32'h40);
      foreach (rows[i]) begin
         alt = rows[i] / 10000; num = (rows[i] / 100) % 100; bn = rows[i] % 100; slow <= i[0];
         sa = 12'(OFS_SLOT_BASE + num * 4);
         apb(1, IDX_CAUSE_SEL_A * 4, 32'(alt) << 4); apb(1, IDX_CAUSE_SEL_B * 4, alt ? 'hC0 : 0);
         apb(1, OFS_MODE, alt); apb(1, sa, 5); pulse(bn); wt(0);
         chk(irq_number, num);
         chk(irq_level, 5);
         apb(0, sa, 0); chk(rdv, 32'hD);
         fetch(6'(num), 0); apb(0, sa, 0); chk(rdv, 5);
         apb(1, sa, 0);
      end
      // Level equal to threshold refuses, one above accepts, enable off refuses
      apb(1, 12'h174, 3); apb(1, OFS_FLAG_WORD, 32'h3040); pulse(0);
      repeat (4) @(negedge clk); chk(irq_request, 0);
      apb(1, OFS_FLAG_WORD, 32'h2040); wt(0); chk(irq_number, 29);
      apb(1, OFS_FLAG_WORD, 0); repeat (3) @(negedge clk); chk(irq_request, 0);
      apb(1, 12'h178, 6); pulse(1); apb(1, OFS_FLAG_WORD, 32'h40); wt(0);
      chk(irq_number, 30);
      apb(1, 12'h178, 32'hB); repeat (2) @(negedge clk); chk(irq_number, 29);
      apb(1, 12'h174, 3); repeat (2) @(negedge clk); chk(irq_number, 30);
      apb(1, 12'h174, 32'hB); apb(0, 12'h174, 0); chk(rdv, 3);
      apb(1, 12'h178, 8); repeat (2) @(negedge clk); chk(irq_request, 0);
      apb(0, 12'h178, 0); chk(rdv, 8);
      // Software vectors ignore the enable flag
      apb(1, OFS_FLAG_WORD, 0); slow <= 1;
      fetch(0, 1); fetch(32, 1); fetch(63, 1);
      apb(0, OFS_HANDLER, 0); chk(rdv, {12'h000, (BASE + 20'hFC) ^ 20'h5A5A5});
      apb(1, 12'h104, 7); apb(0, 12'h104, 0); chk(rdv, 0);
      apb(0, 12'hFFC, 0); chk(erv, 1);
      // Reset in mid-run with a request on offer
      apb(1, 12'h178, 15); apb(1, OFS_FLAG_WORD, 32'h40); wt(0);
      apb(0, OFS_STATUS, 0); chk(rdv, 32'h8000071E);
      @(posedge clk); resetn <= 0;
      repeat (2) @(negedge clk); chk(irq_request, 0);
      @(posedge clk); resetn <= 1;
      apb(0, OFS_FLAG_WORD, 0); chk(rdv, 0);
      apb(0, OFS_VECTOR_BASE, 0); chk(rdv, 0);
      print_verdict;
   end
endmodule // test_variable_vector_interrupt_map
